// ===== design/eip_pkg.sv
/*
  Constants shared by the external pin interrupt logic: register indices,
  field positions, write masks, reset values and sense encodings.
  Assumes a 32-bit APB master; each register index n sits at byte address 4*n.
*/
package eip_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_PC_MASK0  = 8'h09;
  localparam logic [7:0] IDX_PC_MASK1  = 8'h0A;
  localparam logic [7:0] IDX_FLAG      = 8'h0B;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] IDX_PC_MASK2  = 8'h1A;
  localparam logic [7:0] IDX_PROC_CTRL = 8'h35;
  localparam int         PADDR_W       = 10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_EXT      = 0;
  localparam int BIT_PC0      = 4;
  localparam int BIT_PC1      = 5;
  localparam int BIT_PC2      = 6;
  localparam int BIT_SENSE_LO = 6;
  localparam int BIT_SENSE_HI = 7;

  // ****************************************************************
  // Writable bits and reset values
  // ****************************************************************
  localparam logic [7:0] WMASK_FLAG      = 8'h71;
  localparam logic [7:0] WMASK_IRQ_MASK  = 8'h71;
  localparam logic [7:0] WMASK_PC_MASK0  = 8'hFF;
  localparam logic [7:0] WMASK_PC_MASK1  = 8'h0F;
  localparam logic [7:0] WMASK_PC_MASK2  = 8'h3F;
  localparam logic [7:0] WMASK_PROC_CTRL = 8'hC0;
  localparam logic [7:0] RST_REG         = 8'h00;

  // ****************************************************************
  // Sense control encodings and vector lines
  // ****************************************************************
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam int         VEC_EXT    = 0;
  localparam int         VEC_PC0    = 1;
  localparam int         VEC_PC1    = 2;
  localparam int         VEC_PC2    = 3;
  localparam int         NUM_VEC    = 4;
  localparam int         NUM_PC     = 18;

endpackage

// ===== design/eip_pin_sync.sv
/*
  Two-stage synchroniser with a history stage for a group of pins.
  Assumes pins may change at any time relative to pclk.
*/
`timescale 1ns/1ps
module eip_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pins in
  input  wire logic [W-1:0] pin,
  // Synchronised level and change
  output logic      [W-1:0] level,
  output logic      [W-1:0] change
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } eip_sync_state_t;

  eip_sync_state_t s_q;
  eip_sync_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level  = s_q.sync;
  assign change = s_q.sync ^ s_q.prev;

endmodule

// ===== design/eip_top.sv
/*
  External pin interrupt logic: one dedicated pin with selectable sensing,
  eighteen pin-change inputs in three banks, flags, masks and vector requests.
  Assumes an APB master, pins synchronous or not, and a core that pulses
  vec_ack on entry to a service routine and drives the global enable gie.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module eip_top
  import eip_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Processor core
  input  wire logic               gie,
  input  wire logic [NUM_VEC-1:0] vec_ack,
  output logic      [NUM_VEC-1:0] vec_req,
  // Pins
  input  wire logic               ext_pin_irq,
  input  wire logic [NUM_PC-1:0]  pin_change_input,
  output logic                    pc_wake
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]         irq_mask_reg;
    logic [7:0]         irq_flag_reg;
    logic [7:0]         pc_mask_bank0;
    logic [7:0]         pc_mask_bank1;
    logic [7:0]         pc_mask_bank2;
    logic [7:0]         processor_control_reg;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [NUM_VEC-1:0] vec_req;
    logic               pc_wake;
  } eip_state_t;

  eip_state_t s_q;
  eip_state_t s_d;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NUM_PC-1:0] pc_level;
  logic [NUM_PC-1:0] pc_change;
  logic              ext_level;
  logic              ext_change;

  // The pad value is sampled whatever the pin direction
  eip_pin_sync #(.W(NUM_PC)) u_pc_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (pin_change_input),
    .level   (pc_level),
    .change  (pc_change)
  );

  eip_pin_sync #(.W(1)) u_ext_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_pin_irq),
    .level   (ext_level),
    .change  (ext_change)
  );

  // ****************************************************************
  // Event detection
  // ****************************************************************
  logic [1:0]        sense;
  logic              ext_event;
  logic [NUM_PC-1:0] pc_enabled;
  logic [2:0]        pc_set;
  logic              pce0;
  logic              pce1;
  logic              pce2;

  assign sense = s_q.processor_control_reg[BIT_SENSE_HI:BIT_SENSE_LO];
  assign pce0  = s_q.irq_mask_reg[BIT_PC0];
  assign pce1  = s_q.irq_mask_reg[BIT_PC1];
  assign pce2  = s_q.irq_mask_reg[BIT_PC2];

  always_comb begin
    case (sense)
      SENSE_ANY:  ext_event = ext_change;
      SENSE_FALL: ext_event = ext_change & ~ext_level;
      SENSE_RISE: ext_event = ext_change & ext_level;
      default:    ext_event = 1'b0;
    endcase
  end

  // Per-pin gating by mask bit and bank enable
  assign pc_enabled = {s_q.pc_mask_bank2[5:0] & {6{pce2}},
                       s_q.pc_mask_bank1[3:0] & {4{pce1}},
                       s_q.pc_mask_bank0 & {8{pce0}}};

  // Plain clocked compare; no I/O clock gate sits in front of it
  assign pc_set = {|(pc_change[17:12] & pc_enabled[17:12]),
                   |(pc_change[11:8] & pc_enabled[11:8]),
                   |(pc_change[7:0] & pc_enabled[7:0])};

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [7:0] idx;
  logic       idx_ok;
  logic [7:0] rd_val;
  logic       acc;
  logic       wr;

  assign idx = paddr[PADDR_W-1:2];
  assign acc = psel & penable & s_q.pready;
  assign wr  = acc & pwrite & ~s_q.pslverr;

  always_comb begin
    idx_ok = 1'b1;
    if (idx == IDX_PC_MASK0) begin
      rd_val = s_q.pc_mask_bank0;
    end else if (idx == IDX_PC_MASK1) begin
      rd_val = s_q.pc_mask_bank1;
    end else if (idx == IDX_FLAG) begin
      rd_val = s_q.irq_flag_reg;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_val = s_q.irq_mask_reg;
    end else if (idx == IDX_PC_MASK2) begin
      rd_val = s_q.pc_mask_bank2;
    end else if (idx == IDX_PROC_CTRL) begin
      rd_val = s_q.processor_control_reg;
    end else begin
      rd_val = 8'h00;
      idx_ok = 1'b0;
    end
    if (paddr[1:0] != 2'h0) begin
      idx_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic       level_req;

  always_comb begin
    s_d = s_q;

    // One wait-free access: answer is prepared during the setup cycle
    s_d.pready  = psel & ~penable;
    s_d.pslverr = psel & ~penable & ~idx_ok;
    s_d.prdata  = (psel & ~penable & ~pwrite) ? {24'h000000, rd_val} : 32'h00000000;

    // Only the writable bits move, reserved bits stay zero
    if (wr && idx == IDX_PC_MASK0) begin
      s_d.pc_mask_bank0 = pwdata[7:0] & WMASK_PC_MASK0;
    end
    if (wr && idx == IDX_PC_MASK1) begin
      s_d.pc_mask_bank1 = pwdata[7:0] & WMASK_PC_MASK1;
    end
    if (wr && idx == IDX_PC_MASK2) begin
      s_d.pc_mask_bank2 = pwdata[7:0] & WMASK_PC_MASK2;
    end
    if (wr && idx == IDX_IRQ_MASK) begin
      s_d.irq_mask_reg = pwdata[7:0] & WMASK_IRQ_MASK;
    end
    if (wr && idx == IDX_PROC_CTRL) begin
      s_d.processor_control_reg = pwdata[7:0] & WMASK_PROC_CTRL;
    end

    flag_set          = 8'h00;
    flag_set[BIT_EXT] = ext_event;
    flag_set[BIT_PC0] = pc_set[0];
    flag_set[BIT_PC1] = pc_set[1];
    flag_set[BIT_PC2] = pc_set[2];

    flag_clr          = 8'h00;
    if (wr && idx == IDX_FLAG) begin
      flag_clr = pwdata[7:0] & WMASK_FLAG;
    end
    flag_clr[BIT_EXT] = flag_clr[BIT_EXT] | vec_ack[VEC_EXT];
    flag_clr[BIT_PC0] = flag_clr[BIT_PC0] | vec_ack[VEC_PC0];
    flag_clr[BIT_PC1] = flag_clr[BIT_PC1] | vec_ack[VEC_PC1];
    flag_clr[BIT_PC2] = flag_clr[BIT_PC2] | vec_ack[VEC_PC2];

    // A set in the same cycle as a clear wins so no event is lost
    s_d.irq_flag_reg = ((s_q.irq_flag_reg & ~flag_clr) | flag_set) & WMASK_FLAG;
    if (sense == SENSE_LOW) begin
      s_d.irq_flag_reg[BIT_EXT] = 1'b0;
    end

    // Level mode requests for as long as the pin stays low
    level_req = (sense == SENSE_LOW) & ~ext_level;
    s_d.vec_req[VEC_EXT] = s_q.irq_mask_reg[BIT_EXT] & gie &
                           (s_q.irq_flag_reg[BIT_EXT] | level_req);
    s_d.vec_req[VEC_PC0] = s_q.irq_flag_reg[BIT_PC0] & pce0 & gie;
    s_d.vec_req[VEC_PC1] = s_q.irq_flag_reg[BIT_PC1] & pce1 & gie;
    s_d.vec_req[VEC_PC2] = s_q.irq_flag_reg[BIT_PC2] & pce2 & gie;

    // Wake hint independent of gie; core sleep logic decides what to do with it
    s_d.pc_wake = |pc_set | level_req & s_q.irq_mask_reg[BIT_EXT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign vec_req = s_q.vec_req;
  assign pc_wake = s_q.pc_wake;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_level_flag_zero: assert property (
    (sense == SENSE_LOW) && $past(sense == SENSE_LOW) |-> !s_q.irq_flag_reg[BIT_EXT])
    else $error("ext flag set in level mode");

  a_rise_sets_flag: assert property (
    (sense == SENSE_RISE) && ext_change && ext_level |=> s_q.irq_flag_reg[BIT_EXT])
    else $error("rising edge did not set ext flag");

  a_fall_no_rise: assert property (
    (sense == SENSE_FALL) && ext_change && ext_level && !s_q.irq_flag_reg[BIT_EXT]
    |=> !s_q.irq_flag_reg[BIT_EXT])
    else $error("rising edge set flag in falling mode");

  a_write_one_clears: assert property (
    wr && idx == IDX_FLAG && pwdata[BIT_PC0] && !pc_set[0] |=> !s_q.irq_flag_reg[BIT_PC0])
    else $error("write one did not clear bank0 flag");

  a_ack_clears_flag: assert property (
    vec_ack[VEC_PC1] && !pc_set[1] |=> !s_q.irq_flag_reg[BIT_PC1])
    else $error("service entry did not clear bank1 flag");

  a_set_beats_clear: assert property (
    pc_set[2] |=> s_q.irq_flag_reg[BIT_PC2])
    else $error("bank2 event lost");

  a_masked_ignored: assert property (
    $rose(s_q.irq_flag_reg[BIT_PC0]) |-> $past(|(pc_change[7:0] & s_q.pc_mask_bank0) && pce0))
    else $error("bank0 flag without enabled change");

  a_vec_needs_gie: assert property (
    |s_q.vec_req |-> $past(gie))
    else $error("vector request without global enable");

  a_ext_vector: assert property (
    s_q.irq_flag_reg[BIT_EXT] && s_q.irq_mask_reg[BIT_EXT] && gie |=> vec_req[VEC_EXT])
    else $error("ext vector not requested");

  a_reserved_zero: assert property (
    psel && !penable && !pwrite && idx == IDX_FLAG && paddr[1:0] == 2'h0
    |=> prdata[7] == 1'b0 && prdata[3:1] == 3'h0)
    else $error("reserved flag bits read nonzero");

  a_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready not one cycle after setup");

  a_ext_needs_enable: assert property (
    vec_req[VEC_EXT] |-> $past(s_q.irq_mask_reg[BIT_EXT]))
    else $error("ext vector without pin enable");

  a_level_request: assert property (
    (sense == SENSE_LOW) && !ext_level && s_q.irq_mask_reg[BIT_EXT] && gie |=> vec_req[VEC_EXT])
    else $error("low level did not request ext vector");

  a_fall_sets_flag: assert property (
    (sense == SENSE_FALL) && ext_change && !ext_level |=> s_q.irq_flag_reg[BIT_EXT])
    else $error("falling edge did not set ext flag");

  a_any_sets_flag: assert property (
    (sense == SENSE_ANY) && ext_change |=> s_q.irq_flag_reg[BIT_EXT])
    else $error("pin change did not set ext flag");

  a_bank1_gated: assert property (
    $rose(s_q.irq_flag_reg[BIT_PC1]) |-> $past(|(pc_change[11:8] & s_q.pc_mask_bank1[3:0]) && pce1))
    else $error("bank1 flag without enabled change");

  a_bank2_gated: assert property (
    $rose(s_q.irq_flag_reg[BIT_PC2]) |-> $past(|(pc_change[17:12] & s_q.pc_mask_bank2[5:0]) && pce2))
    else $error("bank2 flag without enabled change");

  a_bank0_sets: assert property (
    (|(pc_change[7:0] & s_q.pc_mask_bank0)) && pce0 |=> s_q.irq_flag_reg[BIT_PC0])
    else $error("enabled bank0 change did not set flag");

  a_mask_reserved: assert property (
    psel && !penable && !pwrite && idx == IDX_IRQ_MASK && paddr[1:0] == 2'h0
    |=> prdata[7] == 1'b0 && prdata[3:1] == 3'h0)
    else $error("reserved mask bits read nonzero");

  a_bank_vector: assert property (
    s_q.irq_flag_reg[BIT_PC1] && pce1 && gie |=> vec_req[VEC_PC1])
    else $error("bank1 vector not requested");

  a_wake_pulse: assert property (
    pc_set != 3'h0 |=> pc_wake)
    else $error("bank change did not raise wake hint");

  c_bank0_flag: cover property ($rose(s_q.irq_flag_reg[BIT_PC0]));
  c_bank2_vector: cover property (vec_req[VEC_PC2]);
  c_level_request: cover property ((sense == SENSE_LOW) && vec_req[VEC_EXT]);
  c_any_change: cover property ((sense == SENSE_ANY) && $rose(s_q.irq_flag_reg[BIT_EXT]));
  c_slave_error: cover property (pslverr);

endmodule

// ===== verif/eip_core_model.sv
/*
  Behavioural model of the processor core beside the pin interrupt block:
  it drives the global enable and pulses one vector acknowledge on entry.
  Assumes the bench says when interrupts are on and when the core may answer.
*/
`timescale 1ns/1ps
module eip_core_model
  import eip_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Bench control
  input  wire logic               irq_on,
  input  wire logic               ack_on,
  // Core side of the block
  input  wire logic [NUM_VEC-1:0] vec_req,
  output logic                    gie,
  output logic      [NUM_VEC-1:0] vec_ack
);
  logic [1:0] hold_q;

  // ****************************************************************
  // Vector entry
  // ****************************************************************
  // Hold-off lets the request fall before the next entry is considered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie     <= 1'h0;
      vec_ack <= '0;
      hold_q  <= 2'h0;
    end else begin
      gie     <= irq_on;
      vec_ack <= '0;
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (ack_on && gie && vec_req != '0) begin
        vec_ack <= vec_req & (~vec_req + NUM_VEC'(1));
        hold_q  <= 2'h3;
      end
    end
  end
endmodule

// ===== verif/tb.sv
/*
  Self-checking bench for the pin interrupt block: APB register tasks,
  pin stimulus and a core model that takes vectors.
  Assumes zero or more APB wait states and a 200 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import eip_pkg::*;
  logic               pclk = 1'h0;
  logic               presetn = 1'h0;
  logic               psel = 1'h0;
  logic               penable = 1'h0;
  logic               pwrite = 1'h0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        rdat;
  logic               pready;
  logic               pslverr;
  logic               gie;
  logic               pc_wake;
  logic               ext_pin_irq = 1'h0;
  logic               irq_on = 1'h0;
  logic               ack_on = 1'h0;
  logic [NUM_VEC-1:0] vec_ack;
  logic [NUM_VEC-1:0] vec_req;
  logic [NUM_PC-1:0]  pin_change_input = '0;
  int                 n_errors = 0;
  int                 compares = 0;
  int                 n_wake = 0;
  int                 n_ack[NUM_VEC];
  logic [7:0]         ridx[6] = '{IDX_PC_MASK0, IDX_PC_MASK1, IDX_PC_MASK2, IDX_IRQ_MASK, IDX_PROC_CTRL, IDX_FLAG};
  logic [7:0]         rwm[6] = '{WMASK_PC_MASK0, WMASK_PC_MASK1, WMASK_PC_MASK2, WMASK_IRQ_MASK,
                                 WMASK_PROC_CTRL, 8'h00};
  logic [1:0]         lo = 2'h0;
  int                 bpin[3] = '{7, 8, 17};

  always #2.5 pclk = ~pclk;

  eip_top u_eip_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gie(gie),
    .vec_ack(vec_ack), .vec_req(vec_req), .ext_pin_irq(ext_pin_irq), .pin_change_input(pin_change_input),
    .pc_wake(pc_wake));

  eip_core_model u_eip_core_model (.pclk(pclk), .presetn(presetn), .irq_on(irq_on), .ack_on(ack_on),
    .vec_req(vec_req), .gie(gie), .vec_ack(vec_ack));

  always @(posedge pclk) begin
    if (pc_wake === 1'h1) n_wake++;
    for (int i = 0; i < NUM_VEC; i++) if (vec_ack[i] === 1'h1) n_ack[i]++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic err);
    int g;
    g = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= {idx, lo};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      g++;
    end while (pready !== 1'h1 && g < 50);
    if (pready !== 1'h1) begin
      n_errors++;
      $display("ERROR %0t no APB ready", $time);
    end
    rdat = prdata;
    chk({31'h0, pslverr}, {31'h0, err});
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'h0, idx, 32'h0, 1'h0);
    chk(rdat, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'h1, idx, {24'h0, d}, 1'h0);
  endtask

  task automatic toggle(input int p);
    @(posedge pclk);
    pin_change_input[p] <= ~pin_change_input[p];
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++) rd(ridx[i], 32'h0);
    xfer(1'h0, 8'h10, 32'h0, 1'h1);
    chk(rdat, 32'h0);
    xfer(1'h1, 8'h10, 32'hFF, 1'h1);
    lo = 2'h2;
    xfer(1'h1, IDX_PC_MASK0, 32'hFF, 1'h1);
    lo = 2'h0;
    rd(IDX_PC_MASK0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(ridx[i], 8'hFF);
      rd(ridx[i], {24'h0, rwm[i]});
    end
    for (int b = 0; b < 3; b++) begin
      toggle(bpin[b]);
      cyc(6);
      rd(IDX_FLAG, 32'h1 << (BIT_PC0 + b));
      chk({28'h0, vec_req}, 32'h0);
      wr(IDX_FLAG, 8'h00);
      rd(IDX_FLAG, 32'h1 << (BIT_PC0 + b));
      wr(IDX_FLAG, 8'h1 << (BIT_PC0 + b));
      rd(IDX_FLAG, 32'h0);
    end
    wr(IDX_PC_MASK0, 8'h7F);
    wr(IDX_IRQ_MASK, 8'h51);
    toggle(7);
    toggle(8);
    toggle(12);
    cyc(6);
    rd(IDX_FLAG, 32'h1 << BIT_PC2);
    wr(IDX_FLAG, 8'h40);
    wr(IDX_PC_MASK0, 8'hFF);
    wr(IDX_IRQ_MASK, 8'h71);
    irq_on <= 1'h1;
    ack_on <= 1'h1;
    for (int b = 0; b < 3; b++) begin
      toggle(bpin[b]);
      cyc(12);
      rd(IDX_FLAG, 32'h0);
      chk(n_ack[b + 1], 32'h1);
    end
    chk({31'h0, n_wake != 0}, 32'h1);
    irq_on <= 1'h0;
    ack_on <= 1'h0;
    for (int s = 1; s < 4; s++) begin
      wr(IDX_PROC_CTRL, 8'(s) << BIT_SENSE_LO);
      ext_pin_irq <= 1'h1;
      cyc(6);
      rd(IDX_FLAG, {31'h0, s != 2});
      wr(IDX_FLAG, 8'h01);
      ext_pin_irq <= 1'h0;
      cyc(6);
      rd(IDX_FLAG, {31'h0, s != 3});
      wr(IDX_FLAG, 8'h01);
    end
    ext_pin_irq <= 1'h1;
    cyc(6);
    irq_on <= 1'h1;
    cyc(4);
    chk({28'h0, vec_req}, 32'h1);
    irq_on <= 1'h0;
    wr(IDX_PROC_CTRL, 8'h00);
    ext_pin_irq <= 1'h0;
    rd(IDX_FLAG, 32'h0);
    irq_on <= 1'h1;
    cyc(6);
    chk({28'h0, vec_req}, 32'h1);
    wr(IDX_IRQ_MASK, 8'h70);
    cyc(3);
    chk({28'h0, vec_req}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h71);
    ext_pin_irq <= 1'h1;
    cyc(6);
    chk({28'h0, vec_req}, 32'h0);
    test_done();
  end

  // Watchdog well past the expected run length
  initial begin
    cyc(5000);
    n_errors++;
    test_done();
  end
endmodule
